// ---- design/ifsb_consts.vh ----
`ifndef IFSB_CONSTS_VH
`define IFSB_CONSTS_VH
`define IFSB_NREG          6
`define IFSB_OFF_FLAGS0    12'h000
`define IFSB_OFF_FLAGS1    12'h004
`define IFSB_OFF_FLAGS2    12'h008
`define IFSB_OFF_FLAGS3    12'h00C
`define IFSB_OFF_FLAGS4    12'h010
`define IFSB_OFF_FLAGS5    12'h014
`define IFSB_OFF_EN0       12'h020
`define IFSB_OFF_EN5       12'h034
`define IFSB_OFF_PRI0      12'h040
`define IFSB_OFF_STAT      12'h0C0
`define IFSB_OFF_MASK      12'h0C4
`define IFSB_MASK_FULL0    16'hB9CD
`define IFSB_MASK_FULL1    16'hEA1F
`define IFSB_MASK_FULL2    16'h0020
`define IFSB_MASK_FULL3    16'h0006
`define IFSB_MASK_FULL4    16'h0106
`define IFSB_MASK_FULL5    16'h0001
`define IFSB_MASK_RED1     16'h201F
`define IFSB_MASK_RED3     16'h0000
`define IFSB_MASK_RED4     16'h0102
`define IFSB_FLAG_RESET    16'h0000
`define IFSB_NSRC          96
`endif

// ---- design/ifsb_flag_reg.v ----
`timescale 1ns/1ps
`include "ifsb_consts.vh"
module ifsb_flag_reg #(
   parameter [15:0] IMPL = 16'hFFFF
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [15:0] src_set,
   input  wire        wr_en,
   input  wire [15:0] wr_data,
   output wire [15:0] flags,
   output wire [15:0] new_set
);
   reg  [15:0] flags_r;
   wire [15:0] flags_nxt;
   // hardware set wins over a software clear in the same cycle
   assign flags_nxt = ((wr_en ? wr_data : flags_r) | src_set) & IMPL;
   assign new_set   = src_set & IMPL & ~flags_r;
   assign flags     = flags_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= `IFSB_FLAG_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end
endmodule // ifsb_flag_reg

// ---- design/ifsb_flag_bank.v ----
`timescale 1ns/1ps
`include "ifsb_consts.vh"
// Behaviour
// - a flag reads one after its source requested an interrupt and zero before.
// - every flag is software readable and writable and is zero after reset.
// - bits with no source ignore writes and read zero.
// - flag register 0 high byte holds nvm 15, adc 13, uart1 tx 12, uart1 rx 11, timer3 8.
// - flag register 0 low byte holds timer2 7, capcmp2 6, timer1 3, capcmp1 2, ext irq0 0.
// - flag register 1 high byte holds uart2 tx 15, uart2 rx 14, ext irq2 13, timer4 11, capcmp3 9.
// - flag register 1 low byte holds ext irq1 4, pin change 3, comparator 2, serial1 coll 1, serial1 event 0.
// - flag register 2 implements only bit 5, the timer3 gate event.
// - flag register 3 implements only bit 2 serial2 collision and bit 1 serial2 event.
// - flag register 4 implements bit 8 voltage detect, bit 2 uart2 error, bit 1 uart1 error.
// - flag register 5 implements only bit 0, the low-power wake request.
// - reduced variants drop uart2, timer4, capcmp3 and serial2 flags, which then read zero.
// - with the enhanced unit fitted, the capcmp1 flag position reports that unit's requests.
// - a set flag is forwarded as a request only while its enable bit at the same place is one.
// - each forwarded request carries one of eight software-selected priority levels.
module ifsb_flag_bank #(
   parameter FULL_VARIANT = 1,
   parameter HAS_ENH_CC1  = 0
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        nvm_done_req,
   input  wire        adc_done_req,
   input  wire        uart1_tx_req,
   input  wire        uart1_rx_req,
   input  wire        timer3_req,
   input  wire        timer2_req,
   input  wire        capcmp2_req,
   input  wire        timer1_req,
   input  wire        capcmp1_req,
   input  wire        enhanced_capcmp1_req,
   input  wire        ext_irq0_req,
   input  wire        uart2_tx_req,
   input  wire        uart2_rx_req,
   input  wire        ext_irq2_req,
   input  wire        timer4_req,
   input  wire        capcmp3_req,
   input  wire        ext_irq1_req,
   input  wire        pin_change_req,
   input  wire        comparator_req,
   input  wire        serial1_collision_req,
   input  wire        serial1_event_req,
   input  wire        timer3_gate_req,
   input  wire        serial2_collision_req,
   input  wire        serial2_event_req,
   input  wire        voltage_detect_req,
   input  wire        uart2_error_req,
   input  wire        uart1_error_req,
   input  wire        low_power_wake_req,
   output wire [95:0] irq_pending,
   output wire [287:0] irq_level,
   output wire        irq_out
);
   localparam [15:0] IMPL1 = FULL_VARIANT ? `IFSB_MASK_FULL1 : `IFSB_MASK_RED1;
   localparam [15:0] IMPL3 = FULL_VARIANT ? `IFSB_MASK_FULL3 : `IFSB_MASK_RED3;
   localparam [15:0] IMPL4 = FULL_VARIANT ? `IFSB_MASK_FULL4 : `IFSB_MASK_RED4;
   localparam [95:0] IMPL_ALL = {`IFSB_MASK_FULL5, IMPL4, IMPL3, `IFSB_MASK_FULL2,
                                 IMPL1, `IFSB_MASK_FULL0};

   // source inputs come from peripheral logic on pclk, so no synchroniser
   wire        cc1_src;
   wire [95:0] src;
   wire [95:0] flags;
   wire [95:0] new_set;
   wire [5:0]  flag_wr;
   wire [95:0] enables;
   reg  [287:0] prio_r;
   reg  [5:0]  stat_r;
   reg  [5:0]  mask_r;
   reg  [5:0]  stat_nxt;

   assign cc1_src = HAS_ENH_CC1 ? enhanced_capcmp1_req : capcmp1_req;

   assign src[15:0]  = {nvm_done_req, 1'b0, adc_done_req, uart1_tx_req, uart1_rx_req,
                        2'b00, timer3_req,
                        timer2_req, capcmp2_req, 2'b00, timer1_req, cc1_src,
                        1'b0, ext_irq0_req};
   assign src[31:16] = {uart2_tx_req, uart2_rx_req, ext_irq2_req, 1'b0, timer4_req,
                        1'b0, capcmp3_req, 1'b0,
                        3'b000, ext_irq1_req, pin_change_req, comparator_req,
                        serial1_collision_req, serial1_event_req};
   assign src[47:32] = {10'h000, timer3_gate_req, 5'h00};
   assign src[63:48] = {13'h0000, serial2_collision_req, serial2_event_req, 1'b0};
   assign src[79:64] = {7'h00, voltage_detect_req, 5'h00, uart2_error_req,
                        uart1_error_req, 1'b0};
   assign src[95:80] = {15'h0000, low_power_wake_req};

   // setup phase is enough to decode; every access completes in its access cycle
   wire acc = psel & penable;
   wire wr  = acc & pwrite;
   assign pready = 1'b1;

   function [3:0] reg_idx;
      input [11:0] a;
      input [11:0] base;
      begin
         reg_idx = 4'hF;
         if (a >= base && a < base + 12'h018 && a[1:0] == 2'b00) begin
            reg_idx = a[5:2] - base[5:2];
         end
      end
   endfunction

   wire [3:0] fl_idx = reg_idx(paddr, `IFSB_OFF_FLAGS0);
   wire [3:0] en_idx = reg_idx(paddr, `IFSB_OFF_EN0);
   // twelve priority words, eight sources each
   wire       pr_hit = (paddr >= `IFSB_OFF_PRI0) && (paddr < `IFSB_OFF_PRI0 + 12'h030)
                       && (paddr[1:0] == 2'b00);
   // word index counted from the priority base
   wire [4:0] pr_idx = paddr[6:2] - 5'h10;
   wire       hit = (fl_idx != 4'hF) || (en_idx != 4'hF) || pr_hit ||
                    (paddr == `IFSB_OFF_STAT) || (paddr == `IFSB_OFF_MASK);
   assign pslverr = acc & ~hit;

   genvar g;
   generate
      for (g = 0; g < `IFSB_NREG; g = g + 1) begin : g_reg
         reg [15:0] en_r;
         assign flag_wr[g] = wr & (fl_idx == g);
         ifsb_flag_reg #(
            .IMPL (IMPL_ALL[16*g +: 16])
         ) u_flags (
            .pclk    (pclk),
            .presetn (presetn),
            .src_set (src[16*g +: 16]),
            .wr_en   (flag_wr[g]),
            .wr_data (pwdata[15:0]),
            .flags   (flags[16*g +: 16]),
            .new_set (new_set[16*g +: 16])
         );
         // one register per slice keeps a single driver on each enable word
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_r <= 16'h0000;
            end else if (wr && en_idx == g) begin
               en_r <= pwdata[15:0] & IMPL_ALL[16*g +: 16];
            end
         end
         assign enables[16*g +: 16] = en_r;
      end
      for (g = 0; g < 96; g = g + 1) begin : g_src
         assign irq_pending[g] = flags[g] & enables[g];
         assign irq_level[3*g +: 3] = prio_r[3*g +: 3];
      end
   endgenerate

   // eight 3-bit levels per priority word, twelve words
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_r <= 288'h0;
      end else if (wr && pr_hit) begin
         prio_r[24*pr_idx +: 24] <= pwdata[23:0];
      end
   end

   // summary status: one sticky bit per flag register, cleared on read
   integer i;
   always @* begin
      stat_nxt = stat_r;
      if (acc && !pwrite && paddr == `IFSB_OFF_STAT) begin
         stat_nxt = 6'h00;
      end
      for (i = 0; i < `IFSB_NREG; i = i + 1) begin
         if (|new_set[16*i +: 16]) begin
            stat_nxt[i] = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 6'h00;
         mask_r <= 6'h00;
      end else begin
         stat_r <= stat_nxt;
         if (wr && paddr == `IFSB_OFF_MASK) begin
            mask_r <= pwdata[5:0];
         end
      end
   end

   assign irq_out = |(stat_r & mask_r);

   always @* begin
      prdata = 32'h0000_0000;
      if (fl_idx != 4'hF) begin
         prdata = {16'h0000, flags[16*fl_idx +: 16]};
      end else if (en_idx != 4'hF) begin
         prdata = {16'h0000, enables[16*en_idx +: 16]};
      end else if (pr_hit) begin
         prdata = {8'h00, prio_r[24*pr_idx +: 24]};
      end else if (paddr == `IFSB_OFF_STAT) begin
         prdata = {26'h0, stat_r};
      end else if (paddr == `IFSB_OFF_MASK) begin
         prdata = {26'h0, mask_r};
      end
   end
endmodule // ifsb_flag_bank

// ---- dv/ifsb_flag_bank_assertions.sv ----
`timescale 1ns/1ps
module ifsb_flag_bank_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        timer1_req,
   input wire [95:0] irq_pending,
   input wire        irq_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && penable; endsequence
   sequence s_wr(a); s_acc ##0 pwrite && paddr == a; endsequence
   a_no_wait: assert property (s_acc |-> pready) else $error("wait");
   a_bad_addr: assert property (s_acc ##0 paddr >= 12'h100 |-> pslverr) else $error("err");
   a_rst_idle: assert property ($rose(presetn) |-> !irq_out && !irq_pending)
      else $error("idle");
   a_r0_bits: assert property (s_acc ##0 !pwrite && paddr == 12'h000 |->
      !pslverr && (prdata & ~32'h0000B9CD) == 32'h0) else $error("reg0");
   a_en_gate: assert property (s_wr(12'h020) ##0 !pwdata[3] |=> !irq_pending[3])
      else $error("gate");
   a_set_fwd: assert property (s_wr(12'h020) ##0 pwdata[3] && timer1_req |=>
      irq_pending[3]) else $error("fwd");
   a_flag_clr: assert property (s_wr(12'h000) ##0 !pwdata[3] && !timer1_req |=>
      !irq_pending[3]) else $error("clr");
   // any write may legally drop it, so every cycle without a selected write, reads included, is held to it
   a_flag_hold: assert property (irq_pending[3] && !(psel && pwrite) |=> irq_pending[3])
      else $error("hold");
endmodule // ifsb_flag_bank_chk
bind ifsb_flag_bank ifsb_flag_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer1_req(timer1_req), .irq_pending(irq_pending),
   .irq_out(irq_out));

// ---- dv/ifsb_cpu_model.sv ----
`timescale 1ns/1ps
module ifsb_cpu_model (
   input  wire [95:0] irq_pending,
   output logic [6:0] next_src
);
   // natural order: the lowest forwarded source wins
   always_comb begin
      next_src = 7'h7F;
      for (int k = 95; k >= 0; k--)
         if (irq_pending[k]) next_src = 7'(k);
   end
endmodule // ifsb_cpu_model

// ---- dv/ifsb_flag_bank_tb.sv ----
`timescale 1ns/1ps
module ifsb_flag_bank_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, d;
   logic        pready, pslverr, irq_out, err2;
   logic [31:0] prd2;
   logic [287:0] lvl;
   logic [27:0] rq = 0;
   logic [95:0] pend;
   logic [6:0]  nsrc;
   logic [32:0] q[$], q2[$];
   logic [15:0] ex[6] = '{default: 16'h0};
   int          error_cnt = 0, n_tests = 0;
   // per request line: register in high nibble, bit in low; FF has no flag here
   logic [223:0] map = 224'h504142483132251011121314191B1D1E1F00FF02030607080B0C0D0F;
   logic [95:0] msk = 96'h0001_0106_0006_0020_EA1F_B9CD;
   // reduced variant: no uart2, timer4, capcmp3 or serial2 flags
   logic [95:0] msk2 = 96'h0001_0102_0000_0020_201F_B9CD;
   always #5 pclk = ~pclk;
   ifsb_flag_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nvm_done_req(rq[0]), .adc_done_req(rq[1]), .uart1_tx_req(rq[2]),
      .uart1_rx_req(rq[3]), .timer3_req(rq[4]), .timer2_req(rq[5]), .capcmp2_req(rq[6]),
      .timer1_req(rq[7]), .capcmp1_req(rq[8]), .enhanced_capcmp1_req(rq[9]),
      .ext_irq0_req(rq[10]), .uart2_tx_req(rq[11]), .uart2_rx_req(rq[12]),
      .ext_irq2_req(rq[13]), .timer4_req(rq[14]), .capcmp3_req(rq[15]), .ext_irq1_req(rq[16]),
      .pin_change_req(rq[17]), .comparator_req(rq[18]), .serial1_collision_req(rq[19]),
      .serial1_event_req(rq[20]), .timer3_gate_req(rq[21]), .serial2_collision_req(rq[22]),
      .serial2_event_req(rq[23]), .voltage_detect_req(rq[24]), .uart2_error_req(rq[25]),
      .uart1_error_req(rq[26]), .low_power_wake_req(rq[27]), .irq_pending(pend),
      .irq_level(lvl), .irq_out(irq_out));
   // reduced variant with the enhanced unit shares the bus and answers on its own read port
   ifsb_flag_bank #(.FULL_VARIANT(0), .HAS_ENH_CC1(1)) u_red (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prd2), .pready(), .pslverr(err2), .nvm_done_req(rq[0]), .adc_done_req(rq[1]),
      .uart1_tx_req(rq[2]), .uart1_rx_req(rq[3]), .timer3_req(rq[4]), .timer2_req(rq[5]),
      .capcmp2_req(rq[6]), .timer1_req(rq[7]), .capcmp1_req(rq[8]),
      .enhanced_capcmp1_req(rq[9]), .ext_irq0_req(rq[10]), .uart2_tx_req(rq[11]),
      .uart2_rx_req(rq[12]), .ext_irq2_req(rq[13]), .timer4_req(rq[14]),
      .capcmp3_req(rq[15]), .ext_irq1_req(rq[16]), .pin_change_req(rq[17]),
      .comparator_req(rq[18]), .serial1_collision_req(rq[19]), .serial1_event_req(rq[20]),
      .timer3_gate_req(rq[21]), .serial2_collision_req(rq[22]), .serial2_event_req(rq[23]),
      .voltage_detect_req(rq[24]), .uart2_error_req(rq[25]), .uart1_error_req(rq[26]),
      .low_power_wake_req(rq[27]), .irq_pending(), .irq_level(), .irq_out());
   ifsb_cpu_model u_cpu (.irq_pending(pend), .next_src(nsrc));
   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] e2);
      q.push_back(e);
      q2.push_back(e2);
      apb(0, a, 0);
   endtask
   task automatic irq_is(input logic e);
      @(negedge pclk) cmp({32'h0, irq_out}, {32'h0, e});
      @(posedge pclk);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
         cmp({pslverr, prdata}, q.pop_front());
         cmp({err2, prd2}, q2.pop_front());
      end
   initial begin
      #50us;
      error_cnt++;
      summarize();
   end
   initial begin
      d = $urandom(32'h17954BA3);
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int r = 0; r < 7; r++)
         rd(r < 6 ? 12'(4 * r) : 12'h0C0, 0, 0);
      apb(1, 12'h0C4, 1);
      rq[7] <= 1;
      apb(1, 12'h020, 32'h8);
      rq[7] <= 0;
      irq_is(1);
      cmp({26'h0, nsrc}, 3);
      rd(12'h0C0, 1, 1);
      irq_is(0);
      apb(1, 12'h020, 0);
      apb(1, 12'h000, 0);
      apb(1, 12'h0C4, 0);
      rq[5] <= 1;
      @(posedge pclk) rq[5] <= 0;
      irq_is(0);
      rd(12'h0C0, 1, 1);
      rd(12'h000, 32'h80, 32'h80);
      rd(12'h100, 33'h100000000, 33'h100000000);
      d = $urandom;
      apb(1, 12'h06C, d);
      cmp({9'h0, lvl[287:264]}, {9'h0, d[23:0]});
      rd(12'h06C, {9'h0, d[23:0]}, {9'h0, d[23:0]});
      rd(12'h070, 33'h100000000, 33'h100000000);
      for (int i = 0; i < 12; i++) begin
         d = i < 6 ? 32'hFFFFFFFF : $urandom;
         apb(1, 12'(4 * (i % 6)), d);
         rd(12'(4 * (i % 6)), {17'h0, d[15:0] & msk[16 * (i % 6) +: 16]},
            {17'h0, d[15:0] & msk2[16 * (i % 6) +: 16]});
      end
      for (int r = 0; r < 6; r++)
         apb(1, 12'(4 * r), 0);
      for (int k = 0; k < 28; k++) begin
         rq[k] <= 1;
         @(posedge pclk) rq[k] <= 0;
         @(posedge pclk);
         if (map[8 * k +: 8] != 8'hFF)
            ex[map[8 * k + 4 +: 4]][map[8 * k +: 4]] = 1;
      end
      for (int r = 0; r < 6; r++)
         rd(12'(4 * r), {17'h0, ex[r]},
            {17'h0, ex[r] & msk2[16 * r +: 16]});
      rd(12'h0C0, 33'h3F, 33'h37);
      // the enhanced unit drives the capcmp1 position only where it is fitted
      apb(1, 12'h000, 0);
      rq[9] <= 1;
      @(posedge pclk) rq[9] <= 0;
      @(posedge pclk);
      rd(12'h000, 0, 4);
      apb(1, 12'h000, 0);
      rq[8] <= 1;
      @(posedge pclk) rq[8] <= 0;
      @(posedge pclk);
      rd(12'h000, 4, 0);
      // reset in mid-run with flags and status still set
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int r = 0; r < 7; r++)
         rd(r < 6 ? 12'(4 * r) : 12'h0C0, 0, 0);
      summarize();
   end
endmodule // ifsb_flag_bank_tb
